// ==== hw/hbms_seq.sv ====
// Hub boot and mode sequencer top
// Summary of operation
// - Charge strap class selects six charging sets
// - GPIO is input with pull, or output
// - GPIO changeable at runtime by SMBus/controller
// - Reset low: standby, pins high impedance
// - Reset high: hub runs its boot stages
// - Standby drops all state and disables ports
// - Release: reset, PLL lock, probe, then defaults
// - Signature at FFFA enables external ROM
// - No signature or no SPI strap: default load
// - SPI ROM single/dual bit, mode 0/3
// - Load defaults, then apply strap overrides
// - Slave option plus pull-ups enter SOC stage
// - SOC stage waits forever, no timeout
// - Merge defaults, SOC data and OTP data
// - Idle, suspend without bus power or connect
// - Bus power: charger detect if charging, else connect
// - Connect after detect, hold while bus power
// - Normal mode until system changes mode
// - Straps latched once, on leaving init after the wait and PLL lock
// - Slave option strap selects SMBus slave
`timescale 1ns/1ns
`include "hbms_consts.svh"
module hbms_seq (
  // Clock and chip reset pin
  input wire logic sys_clk,
  input wire logic resetn,
  // Strap classes and strap levels, from pins
  input wire hbms_pkg::hbms_strap_t charge_port_strap,
  input wire hbms_pkg::hbms_strap_t cfg_strap,
  input wire logic spi_mode_strap,
  input wire logic spi_dual_strap,
  input wire logic spi_mode3_strap,
  // Pull-up sense on the SMBus pins, from pins
  input wire logic smb_serial_data_pin,
  input wire logic smb_serial_clock_pin,
  // Bus power and PLL lock, from pins
  input wire logic vbus_pin,
  input wire logic pll_lock,
  // Same-clock requests from the hub core
  input wire logic connect_req,
  input wire logic host_configured,
  input wire logic chg_det_done,
  // Register writes from SMBus slave and feature controller
  input wire hbms_pkg::hbms_wr_t smb_wr,
  input wire hbms_pkg::hbms_wr_t hfc_wr,
  // One-time-programmable image and field use bits
  input wire hbms_pkg::hbms_cfg_t otp_cfg,
  input wire logic [3:0] otp_use,
  // SPI flash read port
  output logic spi_rd_req,
  output logic [15:0] spi_rd_addr,
  input wire logic spi_rd_ack,
  input wire logic [7:0] spi_rd_data,
  output logic spi_dual_en,
  output logic spi_mode3_en,
  // Execution source
  output logic rom_ext_en,
  output logic [15:0] exec_addr,
  // Stage and mode status
  output hbms_pkg::hbms_stage_t stage,
  output logic pll_run,
  output logic smb_slave_en,
  output logic suspend,
  output logic hub_connect,
  output logic [5:0] port_en,
  output hbms_pkg::hbms_cfg_t cfg,
  // GPIO pin drive
  output hbms_pkg::hbms_gpio_t gpio
);
  import hbms_pkg::*;

  // Pin inputs pass two flops before any use
  logic [12:0] pin_raw;
  logic [12:0] pin_s;
  assign pin_raw = {charge_port_strap, cfg_strap, spi_mode_strap,
                    spi_dual_strap, spi_mode3_strap,
                    smb_serial_data_pin, smb_serial_clock_pin,
                    vbus_pin, pll_lock};

  hbms_sync #(.W(13)) u_sync (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .d(pin_raw),
    .q(pin_s)
  );

  logic [2:0] chg_strap_s;
  logic [2:0] cfg_strap_s;
  logic spi_mode_s;
  logic spi_dual_s;
  logic spi_mode3_s;
  logic sda_pu_s;
  logic scl_pu_s;
  logic vbus_s;
  logic lock_s;
  assign {chg_strap_s, cfg_strap_s, spi_mode_s, spi_dual_s, spi_mode3_s,
          sda_pu_s, scl_pu_s, vbus_s, lock_s} = pin_s;

  // State
  hbms_stage_t stage_r;
  hbms_stage_t stage_nxt;
  logic [1:0] init_cnt_r;
  logic [1:0] sig_idx_r;
  logic [2:0] chg_latch_r;
  logic slave_setup_option_r;
  logic spi_mode_latch_r;
  hbms_cfg_t cfg_r;
  logic [3:0] soc_mask_r;
  logic spi_rd_req_r;
  logic [15:0] spi_rd_addr_r;
  logic spi_dual_r;
  logic spi_mode3_r;
  logic rom_ext_r;
  logic [15:0] exec_addr_r;
  logic pll_run_r;
  logic suspend_r;
  logic hub_connect_r;
  logic [5:0] port_en_r;
  hbms_gpio_t gpio_r;

  // Strap class to charging port set
  logic [5:0] chg_decoded;
  assign chg_decoded =
    (chg_latch_r == HBMS_R200K_UP) ? `HBMS_CHG_P1 :
    (chg_latch_r == HBMS_R10K_DN) ? `HBMS_CHG_P12 :
    (chg_latch_r == HBMS_R10K_UP) ? `HBMS_CHG_P123 :
    (chg_latch_r == HBMS_R10_DN) ? `HBMS_CHG_P1234 :
    (chg_latch_r == HBMS_R10_UP) ? `HBMS_CHG_ALL : `HBMS_DEF_CHG_PORTS;

  // Signature byte expected at the current probe index
  logic [7:0] sig_byte;
  logic sig_match;
  logic sig_last;
  assign sig_byte = 8'(`HBMS_SIG_WORD >> {~sig_idx_r, 3'h0});
  assign sig_match = spi_rd_ack && (spi_rd_data == sig_byte);
  assign sig_last = (sig_idx_r == `HBMS_SIG_LEN);

  // Write acceptance: SMBus in SOC stage or normal, controller in normal
  logic in_soc;
  logic in_run;
  logic smb_ok;
  logic hfc_ok;
  hbms_wr_t wr;
  assign in_soc = (stage_r == HBMS_SOC_CFG);
  assign in_run = (stage_r == HBMS_NORMAL);
  assign smb_ok = smb_wr.valid && (in_soc || in_run);
  assign hfc_ok = hfc_wr.valid && in_run;
  assign wr = smb_ok ? smb_wr : (hfc_ok ? hfc_wr : '0);

  // Only an SMBus write to FF in the SOC stage ends it
  logic finish_wr;
  assign finish_wr = in_soc && smb_ok && (smb_wr.addr == `HBMS_REG_FINISH);

  logic bc_on;
  logic pull_ups;
  assign bc_on = |cfg_r.chg_ports;
  assign pull_ups = sda_pu_s && scl_pu_s;

  // Stage transitions
  always_comb begin
    stage_nxt = stage_r;
    unique case (stage_r)
      HBMS_INIT: begin
        if (init_cnt_r == `HBMS_INIT_WAIT && lock_s) begin
          stage_nxt = spi_mode_s ? HBMS_SPI_SIG : HBMS_CFG_RD;
        end
      end
      HBMS_SPI_SIG: begin
        if (spi_rd_ack) begin
          if (!sig_match) begin
            stage_nxt = HBMS_CFG_RD;
          end else if (sig_last) begin
            stage_nxt = HBMS_EXT_ROM;
          end
        end
      end
      HBMS_EXT_ROM: stage_nxt = HBMS_EXT_ROM;
      HBMS_CFG_RD: stage_nxt = HBMS_STRAP;
      HBMS_STRAP: begin
        stage_nxt = (slave_setup_option_r && pull_ups) ?
                    HBMS_SOC_CFG : HBMS_OTP_CFG;
      end
      HBMS_SOC_CFG: begin
        if (finish_wr) begin
          stage_nxt = HBMS_OTP_CFG;
        end
      end
      HBMS_OTP_CFG: stage_nxt = HBMS_IDLE;
      HBMS_IDLE: begin
        if (vbus_s) begin
          stage_nxt = bc_on ? HBMS_CHG_DET : HBMS_CONNECT;
        end
      end
      HBMS_CHG_DET: begin
        if (chg_det_done) begin
          stage_nxt = HBMS_CONNECT;
        end
      end
      HBMS_CONNECT: begin
        if (!vbus_s) begin
          stage_nxt = HBMS_IDLE;
        end else if (host_configured) begin
          stage_nxt = HBMS_NORMAL;
        end
      end
      HBMS_NORMAL: begin
        if (!vbus_s) begin
          stage_nxt = HBMS_IDLE;
        end
      end
      default: stage_nxt = HBMS_INIT;
    endcase
  end

  // Stage register; reset puts everything back to standby
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      stage_r <= HBMS_INIT;
      init_cnt_r <= 2'h0;
    end else begin
      stage_r <= stage_nxt;
      if (stage_r == HBMS_INIT && init_cnt_r != `HBMS_INIT_WAIT) begin
        init_cnt_r <= init_cnt_r + 2'h1;
      end
    end
  end

  // Straps are caught once, clocked, after synchronisers settle
  logic strap_take;
  assign strap_take = (stage_r == HBMS_INIT) && (stage_nxt != HBMS_INIT);
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      chg_latch_r <= 3'h0;
      slave_setup_option_r <= 1'b0;
      spi_mode_latch_r <= 1'b0;
      spi_dual_r <= 1'b0;
      spi_mode3_r <= 1'b0;
    end else if (strap_take) begin
      chg_latch_r <= chg_strap_s;
      slave_setup_option_r <= (cfg_strap_s == HBMS_R200K_UP);
      spi_mode_latch_r <= spi_mode_s;
      spi_dual_r <= spi_dual_s;
      spi_mode3_r <= spi_mode3_s;
    end
  end

  // Signature probe reads four bytes from the top of flash
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      spi_rd_req_r <= 1'b0;
      spi_rd_addr_r <= `HBMS_SIG_ADDR;
      sig_idx_r <= 2'h0;
      rom_ext_r <= 1'b0;
      exec_addr_r <= `HBMS_EXEC_ADDR;
    end else begin
      spi_rd_req_r <= (stage_nxt == HBMS_SPI_SIG);
      if (stage_r == HBMS_SPI_SIG && sig_match && !sig_last) begin
        sig_idx_r <= sig_idx_r + 2'h1;
        spi_rd_addr_r <= spi_rd_addr_r + 16'h0001;
      end
      if (stage_nxt == HBMS_EXT_ROM) begin
        rom_ext_r <= spi_mode_latch_r;
        exec_addr_r <= `HBMS_EXEC_ADDR;
      end
    end
  end

  // Configuration image: defaults, straps, SOC and runtime writes, OTP
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cfg_r <= '0;
      soc_mask_r <= 4'h0;
    end else if (stage_r == HBMS_CFG_RD) begin
      cfg_r.gpio_dir <= `HBMS_DEF_GPIO_DIR;
      cfg_r.gpio_lvl <= `HBMS_DEF_GPIO_LVL;
      cfg_r.gpio_pen <= `HBMS_DEF_GPIO_PEN;
      cfg_r.chg_ports <= chg_decoded;
    end else if (stage_r == HBMS_OTP_CFG) begin
      // SOC writes outrank OTP; OTP outranks defaults
      if (!soc_mask_r[0] && otp_use[0]) cfg_r.gpio_dir <= otp_cfg.gpio_dir;
      if (!soc_mask_r[1] && otp_use[1]) cfg_r.gpio_lvl <= otp_cfg.gpio_lvl;
      if (!soc_mask_r[2] && otp_use[2]) cfg_r.gpio_pen <= otp_cfg.gpio_pen;
      if (!soc_mask_r[3] && otp_use[3]) begin
        cfg_r.chg_ports <= otp_cfg.chg_ports;
      end
    end else if (wr.valid) begin
      unique case (wr.addr)
        `HBMS_REG_GPIO_DIR: begin
          cfg_r.gpio_dir <= wr.data;
          soc_mask_r[0] <= in_soc;
        end
        `HBMS_REG_GPIO_LVL: begin
          cfg_r.gpio_lvl <= wr.data;
          soc_mask_r[1] <= in_soc;
        end
        `HBMS_REG_GPIO_PEN: begin
          cfg_r.gpio_pen <= wr.data;
          soc_mask_r[2] <= in_soc;
        end
        `HBMS_REG_CHG_PORTS: begin
          cfg_r.chg_ports <= wr.data[5:0];
          soc_mask_r[3] <= in_soc;
        end
        default: ; // Unmapped offsets and FF store nothing
      endcase
    end
  end

  // GPIO drive; pulls act only on inputs
  hbms_gpio_t gpio_nxt;
  logic gpio_live;
  assign gpio_live = (stage_r == HBMS_IDLE) || (stage_r == HBMS_CHG_DET)
                     || (stage_r == HBMS_CONNECT) || in_run;
  assign gpio_nxt.oe = gpio_live ? cfg_r.gpio_dir : '0;
  assign gpio_nxt.o = cfg_r.gpio_lvl;
  assign gpio_nxt.pu = gpio_live ?
    (~cfg_r.gpio_dir & cfg_r.gpio_pen & cfg_r.gpio_lvl) : '0;
  assign gpio_nxt.pd = gpio_live ?
    (~cfg_r.gpio_dir & cfg_r.gpio_pen & ~cfg_r.gpio_lvl) : '0;

  // Mode outputs; ports stay off until connect
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pll_run_r <= 1'b0;
      suspend_r <= 1'b0;
      hub_connect_r <= 1'b0;
      port_en_r <= 6'h00;
      gpio_r <= '0;
    end else begin
      pll_run_r <= 1'b1;
      suspend_r <= (stage_r == HBMS_IDLE) && !vbus_s && !connect_req;
      hub_connect_r <= (stage_r == HBMS_CONNECT && vbus_s) || in_run;
      port_en_r <= (in_run || stage_r == HBMS_CONNECT) ? 6'h3F : 6'h00;
      gpio_r <= gpio_nxt;
    end
  end

  // Outputs straight from flops
  assign stage = stage_r;
  assign spi_rd_req = spi_rd_req_r;
  assign spi_rd_addr = spi_rd_addr_r;
  assign spi_dual_en = spi_dual_r;
  assign spi_mode3_en = spi_mode3_r;
  assign rom_ext_en = rom_ext_r;
  assign exec_addr = exec_addr_r;
  assign pll_run = pll_run_r;
  assign smb_slave_en = slave_setup_option_r;
  assign suspend = suspend_r;
  assign hub_connect = hub_connect_r;
  assign port_en = port_en_r;
  assign cfg = cfg_r;
  assign gpio = gpio_r;

endmodule : hbms_seq

// ==== hw/hbms_consts.svh ====
// Constants of the hub boot and mode sequencer
`ifndef HBMS_CONSTS_SVH
`define HBMS_CONSTS_SVH

// Widths
`define HBMS_NGPIO 8
`define HBMS_NPORT 6
`define HBMS_NSTAGE 11

// Register offsets on the configuration write port
`define HBMS_REG_GPIO_DIR 8'h10
`define HBMS_REG_GPIO_LVL 8'h11
`define HBMS_REG_GPIO_PEN 8'h12
`define HBMS_REG_CHG_PORTS 8'h13
`define HBMS_REG_FINISH 8'hFF

// Signature probe in external flash
`define HBMS_SIG_ADDR 16'hFFFA
`define HBMS_EXEC_ADDR 16'h0000
`define HBMS_SIG_LEN 2'h3
`define HBMS_SIG_WORD 32'h32444655

// Internal ROM defaults
`define HBMS_DEF_GPIO_DIR 8'h00
`define HBMS_DEF_GPIO_LVL 8'h00
`define HBMS_DEF_GPIO_PEN 8'h00
`define HBMS_DEF_CHG_PORTS 6'h00

// Charge port masks per strap class
`define HBMS_CHG_P1 6'h01
`define HBMS_CHG_P12 6'h03
`define HBMS_CHG_P123 6'h07
`define HBMS_CHG_P1234 6'h0F
`define HBMS_CHG_ALL 6'h3F

// Cycles after release before straps are trusted
`define HBMS_INIT_WAIT 2'h3

`endif

// ==== hw/hbms_pkg.sv ====
// Types of the hub boot and mode sequencer
`include "hbms_consts.svh"
package hbms_pkg;

  // Boot stages, one-hot
  typedef enum logic [10:0] {
    HBMS_INIT     = 11'h001,
    HBMS_SPI_SIG  = 11'h002,
    HBMS_EXT_ROM  = 11'h004,
    HBMS_CFG_RD   = 11'h008,
    HBMS_STRAP    = 11'h010,
    HBMS_SOC_CFG  = 11'h020,
    HBMS_OTP_CFG  = 11'h040,
    HBMS_IDLE     = 11'h080,
    HBMS_CHG_DET  = 11'h100,
    HBMS_CONNECT  = 11'h200,
    HBMS_NORMAL   = 11'h400
  } hbms_stage_t;

  // Resistor class sensed on a six-level strap
  typedef enum logic [2:0] {
    HBMS_R200K_DN = 3'h0,
    HBMS_R200K_UP = 3'h1,
    HBMS_R10K_DN  = 3'h2,
    HBMS_R10K_UP  = 3'h3,
    HBMS_R10_DN   = 3'h4,
    HBMS_R10_UP   = 3'h5
  } hbms_strap_t;

  // Configuration image
  typedef struct packed {
    logic [`HBMS_NPORT-1:0] chg_ports;
    logic [`HBMS_NGPIO-1:0] gpio_dir;
    logic [`HBMS_NGPIO-1:0] gpio_lvl;
    logic [`HBMS_NGPIO-1:0] gpio_pen;
  } hbms_cfg_t;

  // One register write
  typedef struct packed {
    logic valid;
    logic [7:0] addr;
    logic [7:0] data;
  } hbms_wr_t;

  // GPIO pin drive
  typedef struct packed {
    logic [`HBMS_NGPIO-1:0] o;
    logic [`HBMS_NGPIO-1:0] oe;
    logic [`HBMS_NGPIO-1:0] pu;
    logic [`HBMS_NGPIO-1:0] pd;
  } hbms_gpio_t;

endpackage : hbms_pkg

// ==== hw/hbms_sync.sv ====
// Two-flop level synchroniser for pin inputs
`timescale 1ns/1ns
module hbms_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Asynchronous levels in, synchronised levels out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r;

  // First stage feeds only the second
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule : hbms_sync

// ==== dv/hbms_seq_checker.sv ====
// Assertion checker for the hub boot and mode sequencer
`timescale 1ns/1ns
module hbms_seq_checker (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Watched inputs
  input wire hbms_pkg::hbms_wr_t smb_wr,
  input wire hbms_pkg::hbms_wr_t hfc_wr,
  input wire logic spi_rd_ack,
  input wire logic [7:0] spi_rd_data,
  input wire logic chg_det_done,
  // Watched outputs
  input wire logic [15:0] spi_rd_addr,
  input wire logic rom_ext_en,
  input wire logic [15:0] exec_addr,
  input wire hbms_pkg::hbms_stage_t stage,
  input wire logic [5:0] port_en,
  input wire hbms_pkg::hbms_cfg_t cfg,
  input wire hbms_pkg::hbms_gpio_t gpio
);
  import hbms_pkg::*;

  // Everything here lives in the one clock domain
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  a_reset_init: assert property (
    !$past(resetn) |-> stage == HBMS_INIT && port_en == 6'h00 && cfg == '0)
    else $error("state kept across reset");
  a_stage_code: assert property (
    $onehot(stage))
    else $error("stage code not one-hot");
  a_sig_match: assert property (
    stage == HBMS_SPI_SIG && spi_rd_ack && spi_rd_addr == 16'hFFFD &&
    spi_rd_data == 8'h55 |=> stage == HBMS_EXT_ROM ##1
    rom_ext_en && exec_addr == 16'h0000)
    else $error("valid signature did not enable external ROM");
  a_sig_miss: assert property (
    stage == HBMS_SPI_SIG && spi_rd_ack && spi_rd_addr == 16'hFFFA &&
    spi_rd_data != 8'h32 |=> stage == HBMS_CFG_RD)
    else $error("bad signature did not fall back");
  a_soc_wait: assert property (
    stage == HBMS_SOC_CFG && !(smb_wr.valid && smb_wr.addr == 8'hFF)
    |=> stage == HBMS_SOC_CFG)
    else $error("SOC stage left without finish write");
  a_soc_finish: assert property (
    stage == HBMS_SOC_CFG && smb_wr.valid && smb_wr.addr == 8'hFF
    |=> stage == HBMS_OTP_CFG ##1 stage == HBMS_IDLE)
    else $error("finish write did not merge and idle");
  a_chg_entry: assert property (
    stage == HBMS_IDLE ##1 stage == HBMS_CHG_DET |-> cfg.chg_ports != 6'h00)
    else $error("charger detect with charging off");
  a_chg_done: assert property (
    stage == HBMS_CHG_DET && chg_det_done |=> stage == HBMS_CONNECT)
    else $error("detect done did not connect");
  a_port_en: assert property (
    stage == HBMS_NORMAL |-> port_en == 6'h3F)
    else $error("ports off in normal mode");
  a_gpio_write: assert property (
    stage == HBMS_NORMAL && hfc_wr.valid && !smb_wr.valid &&
    hfc_wr.addr == 8'h10 |=> cfg.gpio_dir == $past(hfc_wr.data) ##1
    gpio.oe == $past(hfc_wr.data, 2))
    else $error("runtime direction write not applied");
endmodule : hbms_seq_checker

// ==== dv/hbms_rom_model.sv ====
// Behavioural external flash answering the signature probe
`timescale 1ns/1ns
module hbms_rom_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Probe read port
  input wire logic spi_rd_req,
  input wire logic [15:0] spi_rd_addr,
  output logic spi_rd_ack,
  output logic [7:0] spi_rd_data,
  // Answer delay and corrupted first signature byte
  input wire logic [3:0] dly,
  input wire logic bad
);
  logic [3:0] cnt_r;
  logic [15:0] off;
  logic [31:0] sig;
  logic [7:0] byte_w;
  // Signature at FFFA..FFFD, erased flash elsewhere; 512 Kbit part assumed
  assign off = spi_rd_addr - 16'hFFFA;
  assign sig = bad ? 32'h33444655 : 32'h32444655;
  assign byte_w = (off < 16'h0004) ? sig[8*(3-off[1:0]) +: 8] : 8'hFF;
  // One byte per ack; data churns between acks so stale values never match
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= 4'h0;
      spi_rd_ack <= 1'b0;
      spi_rd_data <= 8'hA5;
    end else if (spi_rd_req && !spi_rd_ack && cnt_r >= dly) begin
      cnt_r <= 4'h0;
      spi_rd_ack <= 1'b1;
      spi_rd_data <= byte_w;
    end else begin
      cnt_r <= cnt_r + 4'h1;
      spi_rd_ack <= 1'b0;
      spi_rd_data <= ~spi_rd_data;
    end
  end
endmodule : hbms_rom_model

// ==== dv/hbms_seq_test.sv ====
// Self-checking testbench of the hub boot and mode sequencer
`timescale 1ns/1ns
module hbms_seq_test;
  import hbms_pkg::*;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  hbms_strap_t charge_port_strap = HBMS_R200K_DN;
  hbms_strap_t cfg_strap = HBMS_R200K_DN;
  logic spi_mode_strap = 1'b0, spi_dual_strap = 1'b0, spi_mode3_strap = 1'b0;
  logic smb_serial_data_pin = 1'b0, smb_serial_clock_pin = 1'b0;
  logic vbus_pin = 1'b0, pll_lock = 1'b1, connect_req = 1'b0, bad = 1'b0;
  logic host_configured = 1'b0, chg_det_done = 1'b0;
  hbms_wr_t smb_wr = '0, hfc_wr = '0;
  hbms_cfg_t otp_cfg = '0;
  logic [3:0] otp_use = 4'h0, dly = 4'h3;
  logic spi_rd_req, spi_rd_ack, spi_dual_en, spi_mode3_en, rom_ext_en;
  logic pll_run, smb_slave_en, suspend, hub_connect;
  logic [15:0] spi_rd_addr, exec_addr;
  logic [7:0] spi_rd_data;
  logic [5:0] port_en;
  hbms_stage_t stage;
  hbms_cfg_t cfg;
  hbms_gpio_t gpio;
  int n_mismatch = 0, compares = 0;

  // Clock, 40 ns period
  initial forever #20 sys_clk = ~sys_clk;

  hbms_seq u_dut (.sys_clk, .resetn, .charge_port_strap, .cfg_strap,
    .spi_mode_strap, .spi_dual_strap, .spi_mode3_strap,
    .smb_serial_data_pin, .smb_serial_clock_pin, .vbus_pin, .pll_lock,
    .connect_req, .host_configured, .chg_det_done, .smb_wr, .hfc_wr,
    .otp_cfg, .otp_use, .spi_rd_req, .spi_rd_addr, .spi_rd_ack,
    .spi_rd_data, .spi_dual_en, .spi_mode3_en, .rom_ext_en, .exec_addr,
    .stage, .pll_run, .smb_slave_en, .suspend, .hub_connect, .port_en,
    .cfg, .gpio);
  hbms_rom_model u_rom (.sys_clk, .resetn, .spi_rd_req, .spi_rd_addr,
    .spi_rd_ack, .spi_rd_data, .dly, .bad);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic conclude();
    if (n_mismatch == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : conclude

  // Two cycles of reset; straps are set by the caller beforehand
  task automatic boot();
    resetn = 1'b0;
    repeat (2) @(negedge sys_clk);
    resetn = 1'b1;
  endtask : boot

  // Bounded wait, so a stuck stage shows up as a mismatch
  task automatic wait_stage(input hbms_stage_t s);
    for (int i = 0; i < 200 && stage !== s; i++)
      @(negedge sys_clk);
    chk(stage, s);
  endtask : wait_stage

  // One-cycle write pulse, feature controller when h is set
  task automatic wr(input logic h, input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    if (h)
      hfc_wr = {1'b1, a, d};
    else
      smb_wr = {1'b1, a, d};
    @(negedge sys_clk);
    smb_wr = '0;
    hfc_wr = '0;
  endtask : wr

  task automatic t_spi();
    {spi_mode_strap, spi_dual_strap, spi_mode3_strap} = 3'h7;
    boot();
    wait_stage(HBMS_EXT_ROM);
    @(negedge sys_clk);
    chk({rom_ext_en, spi_rd_req}, 2'h2);
    chk(exec_addr, 16'h0000);
    chk({spi_dual_en, spi_mode3_en, pll_run}, 3'h7);
    bad = 1'b1;
    dly = 4'h0;
    {spi_dual_strap, spi_mode3_strap} = 2'h0;
    boot();
    wait_stage(HBMS_IDLE);
    chk(rom_ext_en, 1'b0);
    chk({spi_dual_en, spi_mode3_en}, 2'h0);
    spi_mode_strap = 1'b0;
  endtask : t_spi

  task automatic t_charge();
    logic [5:0] tbl [6] = '{6'h00, 6'h01, 6'h03, 6'h07, 6'h0F, 6'h3F};
    smb_serial_data_pin = 1'b1;
    for (int k = 0; k < 6; k++) begin
      charge_port_strap = hbms_strap_t'(k);
      cfg_strap = (k == 1) ? HBMS_R200K_UP : HBMS_R200K_DN;
      boot();
      wait_stage(HBMS_IDLE);
      chk(cfg.chg_ports, tbl[k]);
    end
    charge_port_strap = HBMS_R200K_DN;
    boot();
    wait_stage(HBMS_IDLE);
    vbus_pin = 1'b1;
    wait_stage(HBMS_CONNECT);
    // Connect and port enables follow the stage by one cycle
    @(negedge sys_clk);
    chk({hub_connect, port_en}, 7'h7F);
    vbus_pin = 1'b0;
    wait_stage(HBMS_IDLE);
    repeat (3) @(negedge sys_clk);
    chk(suspend, 1'b1);
    connect_req = 1'b1;
    repeat (3) @(negedge sys_clk);
    chk(suspend, 1'b0);
    connect_req = 1'b0;
  endtask : t_charge

  task automatic t_soc();
    cfg_strap = HBMS_R200K_UP;
    smb_serial_clock_pin = 1'b1;
    otp_cfg.gpio_pen = 8'hA5;
    otp_use = 4'h4;
    boot();
    wait_stage(HBMS_SOC_CFG);
    chk(smb_slave_en, 1'b1);
    repeat (50) @(negedge sys_clk);
    chk(stage, HBMS_SOC_CFG);
    wr(1'b0, 8'h10, 8'h0F);
    wr(1'b1, 8'h10, 8'h77);
    wr(1'b0, 8'h11, 8'h2A);
    wr(1'b0, 8'h13, 8'h3C);
    wr(1'b0, 8'hFF, 8'h00);
    wait_stage(HBMS_IDLE);
    chk(cfg, {6'h3C, 8'h0F, 8'h2A, 8'hA5});
    // Pin drive trails the image by one cycle
    @(negedge sys_clk);
    chk({gpio.o, gpio.oe, gpio.pu, gpio.pd}, 32'h2A0F2080);
    vbus_pin = 1'b1;
    wait_stage(HBMS_CHG_DET);
    chg_det_done = 1'b1;
    wait_stage(HBMS_CONNECT);
    chg_det_done = 1'b0;
    host_configured = 1'b1;
    wait_stage(HBMS_NORMAL);
    wr(1'b1, 8'h10, 8'hF0);
    @(negedge sys_clk);
    chk(gpio.oe, 8'hF0);
    host_configured = 1'b0;
    @(negedge sys_clk);
    resetn = 1'b0;
    @(negedge sys_clk);
    chk({stage, port_en, gpio.oe, pll_run}, {HBMS_INIT, 15'h0});
    chk(cfg, 30'h0);
  endtask : t_soc

  initial begin
    t_spi();
    t_charge();
    t_soc();
    conclude();
  end

  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    #(40 * 20000);
    n_mismatch++;
    conclude();
  end
endmodule : hbms_seq_test

bind hbms_seq hbms_seq_checker u_chk (.sys_clk, .resetn, .smb_wr, .hfc_wr,
  .spi_rd_ack, .spi_rd_data, .chg_det_done, .spi_rd_addr, .rom_ext_en,
  .exec_addr, .stage, .port_en, .cfg, .gpio);
